// *** verilog/mic_intc.sv ***
// Summary of operation
// - Pin trigger code 00 off, 01 rising, 10 falling, 11 both edges.
// - Edge select: pin 3 bits 7-6, pin 2 5-4, pin 1 3-2, pin 0 1-0.
// - Source events set their request flag regardless of any enable.
// - A set flag vectors only when its enable bit is one.
// - Global enable at zero blocks every interrupt.
// - Taking an interrupt pushes the next PC and loads the source vector.
// - Return from interrupt pops the saved PC off the stack.
// - Servicing any interrupt clears the global enable automatically.
// - Requests arriving while blocked still set their flags.
// - Timer, UART, serial, EEPROM, low-voltage, time-out reach core via group vectors.
// - Control 0: global enable, pin0/pin1/group0 enables, their flags, bit 7 unused.
// - Control 1: converter, time base 0/1, group 1 enables, flags above.
// - Group 0: timer 0 match P/A enables bits 0-1, flags bits 4-5.
// - Group 1: low-voltage, EEPROM, serial, UART enables, flags above.
// - Group 2: timer 1 P/A and bus time-out enables, flags 4, 5, 7.
// - Group 3: timer 2 P/A, timer 3 P/A enables, flags above.
// - Unimplemented bits read as zero.
// - Group service clears only the group flag, not source flags.
// - A full stack blocks acknowledgement of every request.
// - Pin, converter and comparator service clears its own flag.
// - Any flag newly set by hardware during sleep wakes the device.
`timescale 1ns/1ns
`default_nettype none

module mic_intc
	import mic_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// External interrupt pins, asynchronous.
	input wire logic [NUM_PINS-1:0] ext_pin,
	// Peripheral source events.
	input wire mic_events_t events,
	// Core sequencer side.
	input wire logic core_boundary,
	input wire logic [PC_W-1:0] core_pc,
	input wire logic stack_full,
	input wire logic return_from_irq,
	input wire logic sleep_mode,
	output logic irq_take,
	output mic_vec_t irq_vector,
	output logic stack_push,
	output logic [PC_W-1:0] stack_push_pc,
	output logic stack_pop,
	output logic wake
);

	mic_state_t q;
	mic_state_t next_q;

	// Edge detector for one pin under its two-bit trigger code.
	function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
		logic rise;
		logic fall;
		rise = now & ~prev;
		fall = ~now & prev;
		unique case (sel)
			EDGE_OFF: edge_hit = 1'b0;
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			EDGE_BOTH: edge_hit = rise | fall;
		endcase
	endfunction : edge_hit

	// Pending request of one vector: its flag and its enable together.
	function automatic logic vec_pending(input logic [REG_COUNT-1:0][7:0] r, input int v);
		vec_pending = r[VEC_REG[v]][VEC_FLAG_BIT[v]] & r[VEC_REG[v]][VEC_EN_BIT[v]];
	endfunction : vec_pending

	// Next state: sync, decode, software access, service, then hardware sets.
	always_comb begin
		logic [REG_COUNT-1:0][7:0] hw_set;
		logic [NUM_GROUPS-1:0][3:0] grp_src;
		logic [3:0] grp_live;
		logic found;
		logic [3:0] pick;
		logic [1:0] sel;
		next_q = q;
		hw_set = '0;
		grp_src = '0;
		found = 1'b0;
		pick = 4'h0;
		sel = EDGE_OFF;
		grp_live = 4'h0;

		// Three-stage synchroniser; only the second and third stages feed the edge logic.
		next_q.pin_s1 = ext_pin;
		next_q.pin_s2 = q.pin_s1;
		next_q.pin_s3 = q.pin_s2;

		// Pin edges set the pin flags whatever the enables say.
		for (int p = 0; p < NUM_PINS; p++) begin
			sel = q.regs[REG_EDGE_SELECT][EDGE_FIELD_W*p +: EDGE_FIELD_W];
			if (edge_hit(sel, q.pin_s2[p], q.pin_s3[p])) begin
				hw_set[VEC_REG[PIN_VEC[p]]][VEC_FLAG_BIT[PIN_VEC[p]]] = 1'b1;
			end
		end

		// Direct sources set their own flags.
		if (events.conv_done) begin
			hw_set[VEC_REG[VEC_CONV]][VEC_FLAG_BIT[VEC_CONV]] = 1'b1;
		end
		if (events.timebase[0]) begin
			hw_set[VEC_REG[VEC_TB0]][VEC_FLAG_BIT[VEC_TB0]] = 1'b1;
		end
		if (events.timebase[1]) begin
			hw_set[VEC_REG[VEC_TB1]][VEC_FLAG_BIT[VEC_TB1]] = 1'b1;
		end
		if (events.cmp_change[0]) begin
			hw_set[VEC_REG[VEC_CMP0]][VEC_FLAG_BIT[VEC_CMP0]] = 1'b1;
		end
		if (events.cmp_change[1]) begin
			hw_set[VEC_REG[VEC_CMP1]][VEC_FLAG_BIT[VEC_CMP1]] = 1'b1;
		end

		// Shared sources land in group registers, aligned with their enables.
		grp_src[0] = {2'h0, events.tmr_match_a[0], events.tmr_match_p[0]};
		grp_src[1] = {events.serial_async, events.serial_module, events.eeprom, events.low_volt};
		grp_src[2] = {events.bus_timeout, 1'b0, events.tmr_match_a[1], events.tmr_match_p[1]};
		grp_src[3] = {events.tmr_match_a[3], events.tmr_match_p[3],
			events.tmr_match_a[2], events.tmr_match_p[2]};
		for (int g = 0; g < NUM_GROUPS; g++) begin
			hw_set[GRP_REG[g]][GRP_FLAG_LSB +: 4] = grp_src[g];
			// A group flag rises on a new enabled source, so a serviced group does not re-fire
			// from a source flag that software has not cleared yet.
			grp_live = q.regs[GRP_REG[g]][GRP_FLAG_LSB +: 4] & q.regs[GRP_REG[g]][3:0];
			next_q.grp_seen[g] = grp_live;
			if (|(grp_live & ~q.grp_seen[g])) begin
				hw_set[VEC_REG[VEC_GRP_BASE+g]][VEC_FLAG_BIT[VEC_GRP_BASE+g]] = 1'b1;
			end
		end

		// Software write stores only implemented bits.
		if (reg_wr && (int'(reg_addr) < REG_COUNT)) begin
			next_q.regs[reg_addr] = reg_wdata & REG_MASK[reg_addr];
		end

		// Read data stand in the cycle after the strobe; unmapped reads give zero.
		next_q.rdata = 8'h00;
		if (reg_rd && (int'(reg_addr) < REG_COUNT)) begin
			next_q.rdata = q.regs[reg_addr] & REG_MASK[reg_addr];
		end

		// Fixed priority: the lowest pending vector index wins.
		for (int v = NUM_VECTORS - 1; v >= 0; v--) begin
			if (vec_pending(q.regs, v)) begin
				found = 1'b1;
				pick = 4'(v);
			end
		end

		// Acknowledge at an instruction boundary only.
		next_q.core.take = 1'b0;
		next_q.core.push = 1'b0;
		if (core_boundary && found && q.regs[REG_IRQ_CONTROL_0][GIE_BIT] && !stack_full) begin
			next_q.core.take = 1'b1;
			next_q.core.vector = mic_vec_t'(pick);
			next_q.core.push = 1'b1;
			next_q.core.push_pc = core_pc;
			next_q.regs[REG_IRQ_CONTROL_0][GIE_BIT] = 1'b0;
			// Own flag for direct sources, group flag only for group vectors.
			next_q.regs[VEC_REG[pick]][VEC_FLAG_BIT[pick]] = 1'b0;
		end

		// Return pops the saved program counter.
		next_q.core.pop = return_from_irq;

		// A hardware set wins over any clear in the same cycle.
		for (int r = 0; r < REG_COUNT; r++) begin
			next_q.regs[r] = next_q.regs[r] | (hw_set[r] & REG_MASK[r]);
		end

		// Wake on any flag newly set by hardware while asleep.
		next_q.wake = 1'b0;
		for (int r = 0; r < REG_COUNT; r++) begin
			if (sleep_mode && (|(hw_set[r] & REG_MASK[r] & ~q.regs[r]))) begin
				next_q.wake = 1'b1;
			end
		end
	end

	// State register; everything comes up cleared, pins disabled.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register.
	assign reg_rdata = q.rdata;
	assign irq_take = q.core.take;
	assign irq_vector = q.core.vector;
	assign stack_push = q.core.push;
	assign stack_push_pc = q.core.push_pc;
	assign stack_pop = q.core.pop;
	assign wake = q.wake;

endmodule : mic_intc

`default_nettype wire

// *** common/mic_pkg.sv ***
package mic_pkg;

	// Register indices on the plain register port.
	localparam logic [3:0] REG_EDGE_SELECT = 4'h0;
	localparam logic [3:0] REG_IRQ_CONTROL_0 = 4'h1;
	localparam logic [3:0] REG_IRQ_CONTROL_1 = 4'h2;
	localparam logic [3:0] REG_IRQ_CONTROL_2 = 4'h3;
	localparam logic [3:0] REG_IRQ_CONTROL_3 = 4'h4;
	localparam logic [3:0] REG_GROUP_0_SOURCES = 4'h5;
	localparam logic [3:0] REG_GROUP_1_SOURCES = 4'h6;
	localparam logic [3:0] REG_GROUP_2_SOURCES = 4'h7;
	localparam logic [3:0] REG_GROUP_3_SOURCES = 4'h8;
	localparam int REG_COUNT = 9;
	localparam int NUM_PINS = 4;
	localparam int NUM_GROUPS = 4;
	localparam int NUM_VECTORS = 13;
	localparam int PC_W = 13;

	// Implemented bits of each register; all others read as zero.
	localparam logic [REG_COUNT-1:0][7:0] REG_MASK = {
		8'hff, 8'hbb, 8'hff, 8'h33, 8'h33, 8'hff, 8'hff, 8'h7f, 8'hff
	};
	localparam logic [7:0] REG_RESET = 8'h00;

	// Global enable position in control register 0.
	localparam logic [2:0] GIE_BIT = 3'h0;

	// Trigger codes of the two-bit per-pin field.
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int EDGE_FIELD_W = 2;

	// Group source registers: enables in the low nibble, flags in the high nibble.
	localparam int GRP_FLAG_LSB = 4;
	localparam logic [NUM_GROUPS-1:0][3:0] GRP_REG = {
		REG_GROUP_3_SOURCES, REG_GROUP_2_SOURCES, REG_GROUP_1_SOURCES, REG_GROUP_0_SOURCES
	};

	// Vector identifiers, in fixed priority order, index 0 highest.
	typedef enum logic [3:0] {
		VEC_PIN0 = 4'h0,
		VEC_PIN1 = 4'h1,
		VEC_CONV = 4'h2,
		VEC_TB0 = 4'h3,
		VEC_TB1 = 4'h4,
		VEC_GRP0 = 4'h5,
		VEC_GRP1 = 4'h6,
		VEC_GRP2 = 4'h7,
		VEC_GRP3 = 4'h8,
		VEC_CMP0 = 4'h9,
		VEC_CMP1 = 4'ha,
		VEC_PIN2 = 4'hb,
		VEC_PIN3 = 4'hc
	} mic_vec_t;
	localparam int VEC_GRP_BASE = 5;

	// Per vector: register, enable bit and request flag bit, listed from vector 12 down to 0.
	localparam logic [NUM_VECTORS-1:0][3:0] VEC_REG = {
		4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h1, 4'h2, 4'h2, 4'h2, 4'h1, 4'h1
	};
	localparam logic [NUM_VECTORS-1:0][2:0] VEC_EN_BIT = {
		3'h1, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h2, 3'h1
	};
	localparam logic [NUM_VECTORS-1:0][2:0] VEC_FLAG_BIT = {
		3'h5, 3'h4, 3'h7, 3'h6, 3'h5, 3'h4, 3'h7, 3'h6, 3'h6, 3'h5, 3'h4, 3'h5, 3'h4
	};

	// Vector of each external pin, pin 3 first.
	localparam logic [NUM_PINS-1:0][3:0] PIN_VEC = {4'hc, 4'hb, 4'h1, 4'h0};

	// Peripheral source events, each a one-cycle pulse on ref_clk.
	typedef struct packed {
		logic [3:0] tmr_match_p;
		logic [3:0] tmr_match_a;
		logic conv_done;
		logic [1:0] timebase;
		logic [1:0] cmp_change;
		logic low_volt;
		logic eeprom;
		logic serial_module;
		logic serial_async;
		logic bus_timeout;
	} mic_events_t;

	// Answer to the core sequencer.
	typedef struct packed {
		logic take;
		mic_vec_t vector;
		logic push;
		logic [PC_W-1:0] push_pc;
		logic pop;
	} mic_core_t;

	// Whole state of the controller.
	typedef struct packed {
		logic [REG_COUNT-1:0][7:0] regs;
		logic [NUM_PINS-1:0] pin_s1;
		logic [NUM_PINS-1:0] pin_s2;
		logic [NUM_PINS-1:0] pin_s3;
		logic [NUM_GROUPS-1:0][3:0] grp_seen;
		logic [7:0] rdata;
		logic wake;
		mic_core_t core;
	} mic_state_t;

endpackage : mic_pkg

// *** bench/mic_intc_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module mic_intc_checker
	import mic_pkg::*;
(
	// Clock, reset and register port.
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Core side.
	input wire logic core_boundary,
	input wire logic [PC_W-1:0] core_pc,
	input wire logic stack_full,
	input wire logic return_from_irq,
	input wire logic sleep_mode,
	input wire logic irq_take,
	input wire mic_vec_t irq_vector,
	input wire logic stack_push,
	input wire logic [PC_W-1:0] stack_push_pc,
	input wire logic stack_pop,
	input wire logic wake
);
	// One clock domain, so clocking and reset are stated once.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_push_with_take: assert property (irq_take == stack_push) else $error("push and take differ");
	a_pc_saved: assert property (irq_take |-> stack_push_pc == $past(core_pc)) else $error("bad saved pc");
	a_vector_held: assert property (!irq_take |-> $stable(irq_vector)) else $error("vector moved");
	a_take_room: assert property (irq_take |-> $past(core_boundary) && !$past(stack_full))
		else $error("take without room");
	a_single_take: assert property (irq_take |=> !irq_take) else $error("take repeated");
	a_pop_follows: assert property (return_from_irq |=> stack_pop ##1 !stack_pop) else $error("pop missing");
	a_unused_zero: assert property ($past(reg_rd) && $past(reg_addr) == REG_IRQ_CONTROL_3 |->
		reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0) else $error("unused bits set");
	a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h8 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_wake_sleep: assert property (wake |-> $past(sleep_mode)) else $error("wake outside sleep");
	// Main scenarios that the bench should reach.
	c_group_take: cover property (irq_take && irq_vector == VEC_GRP1);
	c_pop: cover property (stack_pop);
	c_wake: cover property (wake);
endmodule : mic_intc_checker
bind mic_intc mic_intc_checker u_mic_intc_checker (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_boundary(core_boundary), .core_pc(core_pc),
	.stack_full(stack_full), .return_from_irq(return_from_irq), .sleep_mode(sleep_mode), .irq_take(irq_take),
	.irq_vector(irq_vector), .stack_push(stack_push), .stack_push_pc(stack_push_pc), .stack_pop(stack_pop),
	.wake(wake));
`default_nettype wire

// *** bench/mic_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mic_core_model
	import mic_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Controller answers and pace.
	input wire logic irq_take,
	input wire logic [PC_W-1:0] stack_push_pc,
	input wire logic slow,
	// Sequencer requests.
	output logic core_boundary,
	output logic [PC_W-1:0] core_pc,
	output logic return_from_irq
);
	logic [3:0] busy;

	// Runs code, jumps on a take and returns after a short service routine.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_boundary <= 1'b0;
			core_pc <= '0;
			return_from_irq <= 1'b0;
			busy <= 4'h0;
		end else begin
			core_boundary <= slow ? ~core_boundary : 1'b1;
			return_from_irq <= (busy == 4'h2);
			if (irq_take) begin
				busy <= 4'h9;
				core_pc <= 13'h0010;
			end else if (busy == 4'h1) begin
				busy <= 4'h0;
				core_pc <= stack_push_pc;
			end else begin
				busy <= busy - {3'h0, busy != 4'h0};
				core_pc <= core_pc + 13'h0001;
			end
		end
	end
endmodule : mic_core_model
`default_nettype wire

// *** bench/mic_intc_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module mic_intc_tb
	import mic_pkg::*;
;
	logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stack_full = 1'b0, sleep_mode = 1'b0;
	logic slow = 1'b0, core_boundary, return_from_irq, irq_take, stack_push, stack_pop, wake;
	logic [3:0] reg_addr = 4'h0, ext_pin = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [PC_W-1:0] core_pc, stack_push_pc;
	mic_events_t events = '0;
	mic_vec_t irq_vector;
	int err_count = 0, comparisons = 0, cyc = 0, takes = 0, wakes = 0, pops = 0;

	mic_intc u_mic_intc (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .events(events),
		.core_boundary(core_boundary), .core_pc(core_pc), .stack_full(stack_full),
		.return_from_irq(return_from_irq), .sleep_mode(sleep_mode), .irq_take(irq_take),
		.irq_vector(irq_vector), .stack_push(stack_push), .stack_push_pc(stack_push_pc),
		.stack_pop(stack_pop), .wake(wake));
	mic_core_model u_mic_core_model (.ref_clk(ref_clk), .arst_n(arst_n), .irq_take(irq_take),
		.stack_push_pc(stack_push_pc), .slow(slow), .core_boundary(core_boundary), .core_pc(core_pc),
		.return_from_irq(return_from_irq));

	// Clock generator.
	always #20 ref_clk = ~ref_clk;

	// Pulse counters and the hang limit; the run needs well under a thousand cycles.
	always @(posedge ref_clk) begin
		cyc++;
		if (irq_take === 1'b1) takes++;
		if (wake === 1'b1) wakes++;
		if (stack_pop === 1'b1) pops++;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end

	task final_report;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so it is sampled there.
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, "read");
	endtask : rd

	task take(input mic_vec_t exp);
		int n;
		n = 0;
		while (irq_take !== 1'b1 && n < 30) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk({7'h0, irq_take}, 8'h01, "take");
		chk({4'h0, irq_vector}, {4'h0, exp}, "vector");
	endtask : take

	task pin_edge(input int p, input logic lvl, input logic hit);
		logic [3:0] a;
		a = p < 2 ? REG_IRQ_CONTROL_0 : REG_IRQ_CONTROL_3;
		@(posedge ref_clk);
		ext_pin[p] <= lvl;
		repeat (5) @(posedge ref_clk);
		rd(a, hit ? 8'(8'h01 << (p < 2 ? 4 + p : 2 + p)) : 8'h00);
		wr(a, 8'h00);
	endtask : pin_edge

	initial begin
		logic [8:0][7:0] pat;
		void'($urandom(32'hac359fe2));
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 10; i++) rd(i[3:0], 8'h00);
		// Random patterns with takes held off; groups first so later control writes win.
		stack_full <= 1'b1;
		repeat (4) begin
			for (int i = 8; i >= 0; i--) begin
				pat[i] = 8'($urandom);
				wr(i[3:0], pat[i]);
			end
			for (int i = 0; i < 9; i++) rd(i[3:0], pat[i] & REG_MASK[i]);
		end
		for (int i = 8; i >= 0; i--) wr(i[3:0], 8'h00);
		// Every peripheral source event pulses once while asleep and with all enables off; the pins stay low.
		sleep_mode <= 1'b1;
		@(posedge ref_clk);
		events <= '1;
		@(posedge ref_clk);
		events <= '0;
		repeat (3) @(posedge ref_clk);
		sleep_mode <= 1'b0;
		stack_full <= 1'b0;
		chk({7'h0, wakes != 0}, 8'h01, "wake");
		rd(REG_IRQ_CONTROL_1, 8'h70);
		rd(REG_IRQ_CONTROL_2, 8'hc0);
		rd(REG_GROUP_0_SOURCES, 8'h30);
		rd(REG_GROUP_1_SOURCES, 8'hf0);
		rd(REG_GROUP_2_SOURCES, 8'hb0);
		rd(REG_GROUP_3_SOURCES, 8'hf0);
		// Group 1 is enabled here already, so its later request can reach the core.
		wr(REG_IRQ_CONTROL_1, 8'h7f);
		repeat (10) @(posedge ref_clk);
		chk(takes[7:0], 8'h00, "no take");
		stack_full <= 1'b1;
		wr(REG_IRQ_CONTROL_0, 8'h01);
		repeat (10) @(posedge ref_clk);
		chk(takes[7:0], 8'h00, "full stack");
		stack_full <= 1'b0;
		take(VEC_CONV);
		rd(REG_IRQ_CONTROL_1, 8'h6f);
		rd(REG_IRQ_CONTROL_0, 8'h00);
		slow <= 1'b1;
		wr(REG_IRQ_CONTROL_0, 8'h01);
		take(VEC_TB0);
		wr(REG_IRQ_CONTROL_0, 8'h01);
		take(VEC_TB1);
		slow <= 1'b0;
		// The UART source reaches the core only through its group.
		wr(REG_GROUP_1_SOURCES, 8'hf8);
		rd(REG_IRQ_CONTROL_1, 8'h8f);
		wr(REG_IRQ_CONTROL_0, 8'h01);
		take(VEC_GRP1);
		rd(REG_GROUP_1_SOURCES, 8'hf8);
		rd(REG_IRQ_CONTROL_1, 8'h0f);
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 4; c++) begin
				wr(REG_EDGE_SELECT, 8'(c << (2 * p)));
				pin_edge(p, 1'b1, c[0]);
				pin_edge(p, 1'b0, c[1]);
			end
		end
		// A service routine left to run to its end returns, so at least one saved address must have been popped.
		chk({7'h0, pops != 0}, 8'h01, "pop");
		final_report();
	end
endmodule : mic_intc_tb
`default_nettype wire
